//--- hdl/asw_pkg.sv
// Constants for the addressable switch slave: command codes and slot timing.
// Assumes a 100 MHz clk; all times are converted to cycle counts here.
package asw_pkg;
  localparam int CLK_MHZ = 100;
  // Command bytes, sent least significant bit first
  localparam logic [7:0] CMD_READ_ID = 8'h33;
  localparam logic [7:0] CMD_MATCH = 8'h55;
  localparam logic [7:0] CMD_SEARCH = 8'hf0;
  localparam logic [7:0] CMD_SEARCH_ACT = 8'hec;
  localparam logic [7:0] CMD_SKIP = 8'hcc;
  // Times in microseconds
  localparam int T_RESET_MIN_US = 480;
  localparam int T_PRES_WAIT_US = 30;
  localparam int T_PRES_LEN_US = 120;
  localparam int T_SAMPLE_US = 30;
  localparam int T_RDHOLD_US = 45;
  // Cycle counts: whole microseconds times CLK_MHZ, so no rounding
  localparam int RESET_CYC = T_RESET_MIN_US * CLK_MHZ;
  localparam int PRES_WAIT_CYC = T_PRES_WAIT_US * CLK_MHZ;
  localparam int PRES_LEN_CYC = T_PRES_LEN_US * CLK_MHZ;
  localparam int SAMPLE_CYC = T_SAMPLE_US * CLK_MHZ;
  localparam int RDHOLD_CYC = T_RDHOLD_US * CLK_MHZ;
  localparam int CNT_W = 16;
  localparam int ID_BITS = 64;
  // Default identity code; value is arbitrary
  localparam logic [63:0] ID_DEFAULT = 64'h5a00_0000_0000_0112;
  typedef enum logic [2:0] {
    ASW_IDLE, ASW_PRES, ASW_CMD, ASW_READID, ASW_MATCH, ASW_LEVEL, ASW_SEARCH, ASW_SLEEP
  } asw_state_t;
endpackage : asw_pkg

//--- hdl/asw_slave.sv
// Single-wire addressable switch slave: command layer and slot engine.
// Assumes an external pullup on the line and on the switch pin; line is open drain.
`timescale 1ns/1ns
// Functional notes
// R1 - Full match inverts the switch transistor
// R2 - Mismatch on match: sleep until reset
// R3 - After match, read slots report switch level
// R4 - Pin low sends 0, pin high 1
// R5 - Level reporting continues until bus reset
// R6 - Search command runs bitwise elimination over id
// R7 - Per bit: true, complement, then master write
// R8 - Differing written bit deselects for the search
// R9 - Lone survivor answers read slots with level
// R10 - Active search only when transistor on, pin low
// R11 - Skip command is not acted upon
// R12 - Only storage is fixed 64-bit identity
// R13 - Master reads identity as eight bytes
// R14 - Master sends identity LSB byte first
// R15 - Master reads level byte as ff/00
// R16 - Master repeats addressing to toggle again
// R17 - Master byte write is eight write slots
// R18 - Master byte read is eight read slots
// R19 - Master stops without presence pulse; bench skips only the command byte, later bytes and slots still go out
// R20 - Reset low at least 480 us
// R21 - Slots start at falling edge, 60 us
// R22 - Bytes travel least significant bit first
// R23 - Match command is 55h then identity
// R24 - Open-drain only, released after each slot
// R25 - Write slots sampled at fixed point
module asw_slave #(
  parameter logic [63:0] ID_CODE = asw_pkg::ID_DEFAULT,
  parameter int RESET_CYC = asw_pkg::RESET_CYC,
  parameter int PRES_WAIT_CYC = asw_pkg::PRES_WAIT_CYC,
  parameter int PRES_LEN_CYC = asw_pkg::PRES_LEN_CYC,
  parameter int SAMPLE_CYC = asw_pkg::SAMPLE_CYC,
  parameter int RDHOLD_CYC = asw_pkg::RDHOLD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus line, open drain
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe_n,
  // Switch output pin, open drain
  input wire logic switch_output_pin_in,
  output logic switch_output_pin_out,
  output logic switch_output_pin_oe_n,
  // Status
  output logic switch_on,
  output logic selected
);
  // Line and switch pin synchronisers
  logic dq_s1, dq_s2, dq_prev, sw_s1, sw_s2;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1 <= 1'b1;
      dq_s2 <= 1'b1;
      dq_prev <= 1'b1;
      sw_s1 <= 1'b1;
      sw_s2 <= 1'b1;
    end else begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      dq_prev <= dq_s2;
      sw_s1 <= switch_output_pin_in;
      sw_s2 <= sw_s1;
    end
  end

  wire fall = dq_prev && !dq_s2;

  // Low-time counter for bus reset detection
  logic [asw_pkg::CNT_W-1:0] low_cnt;
  logic bus_reset;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= '0;
      bus_reset <= 1'b0;
    end else begin
      bus_reset <= 1'b0;
      if (dq_s2) begin
        if (low_cnt >= RESET_CYC[asw_pkg::CNT_W-1:0]) begin
          bus_reset <= 1'b1; // Reset ends on the rising edge
        end
        low_cnt <= '0;
      end else if (low_cnt != '1) begin
        low_cnt <= low_cnt + 1'b1;
      end
    end
  end

  // Slot timer: counts from each falling edge
  logic [asw_pkg::CNT_W-1:0] slot_cnt;
  logic in_slot;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_cnt <= '0;
      in_slot <= 1'b0;
    end else if (fall) begin
      slot_cnt <= '0; // R21
      in_slot <= 1'b1;
    end else if (in_slot) begin
      slot_cnt <= slot_cnt + 1'b1;
      if (slot_cnt == RDHOLD_CYC[asw_pkg::CNT_W-1:0]) begin
        in_slot <= 1'b0;
      end
    end
  end

  // Sampling point of a write slot; also the end of a read slot
  wire sample = in_slot && (slot_cnt == SAMPLE_CYC[asw_pkg::CNT_W-1:0]); // R25
  wire bit_val = dq_s2;

  // Presence pulse timer
  logic [asw_pkg::CNT_W-1:0] pres_cnt;
  logic pres_busy, pres_drive;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pres_cnt <= '0;
      pres_busy <= 1'b0;
      pres_drive <= 1'b0;
    end else if (bus_reset) begin
      pres_cnt <= '0;
      pres_busy <= 1'b1;
      pres_drive <= 1'b0;
    end else if (pres_busy) begin
      pres_cnt <= pres_cnt + 1'b1;
      if (pres_cnt == PRES_WAIT_CYC[asw_pkg::CNT_W-1:0]) begin
        pres_drive <= 1'b1;
      end
      if (pres_cnt == PRES_WAIT_CYC[asw_pkg::CNT_W-1:0] +
          PRES_LEN_CYC[asw_pkg::CNT_W-1:0]) begin
        pres_drive <= 1'b0; // R24
        pres_busy <= 1'b0;
      end
    end
  end

  // Command state machine
  asw_pkg::asw_state_t state;
  logic [7:0] cmd_sh;
  logic [6:0] bit_idx;
  logic [1:0] phase; // Search: 0 true, 1 complement, 2 master write
  wire id_bit = ID_CODE[bit_idx[5:0]]; // R12 R22
  wire sw_level = sw_s2;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= asw_pkg::ASW_IDLE;
      cmd_sh <= 8'h00;
      bit_idx <= 7'h00;
      phase <= 2'h0;
      switch_on <= 1'b0;
    end else if (bus_reset) begin
      state <= asw_pkg::ASW_PRES; // R2 R5
      cmd_sh <= 8'h00;
      bit_idx <= 7'h00;
      phase <= 2'h0;
    end else begin
      unique case (state)
        asw_pkg::ASW_IDLE: begin
        end
        asw_pkg::ASW_PRES: begin
          if (!pres_busy) begin
            state <= asw_pkg::ASW_CMD;
          end
        end
        asw_pkg::ASW_CMD: begin
          if (sample) begin
            cmd_sh <= {bit_val, cmd_sh[7:1]}; // R22
            bit_idx <= bit_idx + 1'b1;
            if (bit_idx == 7'd7) begin
              bit_idx <= 7'h00;
              phase <= 2'h0;
              unique case ({bit_val, cmd_sh[7:1]})
                asw_pkg::CMD_READ_ID: state <= asw_pkg::ASW_READID;
                asw_pkg::CMD_MATCH: state <= asw_pkg::ASW_MATCH; // R23
                asw_pkg::CMD_SEARCH: state <= asw_pkg::ASW_SEARCH; // R6
                asw_pkg::CMD_SEARCH_ACT: begin
                  // Eligibility fixed once, when the command byte completes
                  // R10
                  state <= (switch_on && !sw_level) ? asw_pkg::ASW_SEARCH
                                                      : asw_pkg::ASW_SLEEP;
                end
                default: state <= asw_pkg::ASW_SLEEP; // R11
              endcase
            end
          end
        end
        asw_pkg::ASW_READID: begin
          if (sample) begin
            bit_idx <= bit_idx + 1'b1;
            if (bit_idx == 7'd63) begin
              state <= asw_pkg::ASW_SLEEP;
            end
          end
        end
        asw_pkg::ASW_MATCH: begin
          if (sample) begin
            bit_idx <= bit_idx + 1'b1;
            if (bit_val != id_bit) begin
              state <= asw_pkg::ASW_SLEEP; // R2
            end else if (bit_idx == 7'd63) begin
              switch_on <= !switch_on; // R1
              state <= asw_pkg::ASW_LEVEL; // R3
            end
          end
        end
        asw_pkg::ASW_SEARCH: begin
          if (sample) begin
            if (phase == 2'h2) begin
              phase <= 2'h0;
              bit_idx <= bit_idx + 1'b1;
              if (bit_val != id_bit) begin
                state <= asw_pkg::ASW_SLEEP; // R8
              end else if (bit_idx == 7'd63) begin
                state <= asw_pkg::ASW_LEVEL; // R9
              end
            end else begin
              phase <= phase + 1'b1; // R7
            end
          end
        end
        asw_pkg::ASW_LEVEL: begin
        end
        asw_pkg::ASW_SLEEP: begin
        end
      endcase
    end
  end

  // Bit the device offers in the current read slot, if any
  logic tx_en, tx_bit;
  always_comb begin
    tx_en = 1'b0;
    tx_bit = 1'b1;
    unique case (state)
      asw_pkg::ASW_READID: begin
        tx_en = 1'b1;
        tx_bit = id_bit;
      end
      asw_pkg::ASW_SEARCH: begin
        tx_en = (phase != 2'h2);
        tx_bit = (phase == 2'h0) ? id_bit : !id_bit; // R7
      end
      asw_pkg::ASW_LEVEL: begin
        tx_en = 1'b1;
        tx_bit = sw_level; // R3 R4 R5
      end
      default: begin
        tx_en = 1'b0;
        tx_bit = 1'b1;
      end
    endcase
  end

  // Slot pulldown registered so the pin never glitches
  logic slot_drive;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_drive <= 1'b0;
    end else if (fall && tx_en && !tx_bit) begin
      slot_drive <= 1'b1;
    end else if (!in_slot || sample || bus_reset) begin
      slot_drive <= 1'b0; // R24
    end
  end

  // Open-drain outputs: data low, enable active low while pulling
  assign dq_out = 1'b0;
  assign dq_oe_n = !(pres_drive || slot_drive); // R24
  assign switch_output_pin_out = 1'b0;
  assign switch_output_pin_oe_n = !switch_on;
  assign selected = (state == asw_pkg::ASW_LEVEL);
endmodule : asw_slave

//--- dv/asw_slave_checker.sv
// Checker for the switch slave: line and switch pin timing.
// Assumes a bind onto asw_slave with its cycle parameters.
`timescale 1ns/1ns
module asw_slave_checker #(
  parameter int RESET_CYC = 200,
  parameter int PRES_WAIT_CYC = 10,
  parameter int PRES_LEN_CYC = 40
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Line and switch pin
  input wire logic dq_in,
  input wire logic dq_out,
  input wire logic dq_oe_n,
  input wire logic switch_output_pin_in,
  input wire logic switch_output_pin_out,
  input wire logic switch_output_pin_oe_n,
  // Status
  input wire logic switch_on,
  input wire logic selected
);
  localparam int PW_LO = PRES_WAIT_CYC;
  localparam int PW_HI = PRES_WAIT_CYC + 8;
  localparam int HOLD_MAX = PRES_LEN_CYC + 3;
  logic [15:0] lo_cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Length of the current low; margin keeps lows barely over RESET_CYC out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      lo_cnt <= 16'h0;
    else
      lo_cnt <= dq_in ? 16'h0 : lo_cnt + 16'h1;
  end
  sequence s_bus_reset;
    (int'(lo_cnt) >= RESET_CYC + 2) ##1 dq_in;
  endsequence
  a_od_data_low: assert property (!dq_out && !switch_output_pin_out)
    else $error("open-drain data not low");
  a_sw_oe_track: assert property (switch_output_pin_oe_n == !switch_on)
    else $error("switch pulldown differs from state");
  a_slot_release: assert property ($fell(dq_oe_n) |-> ##[1:HOLD_MAX] dq_oe_n)
    else $error("line pulldown not released");
  a_reply_in_slot: assert property (selected && $fell(dq_oe_n) |-> !$past(dq_in))
    else $error("reply without master slot");
  a_zero_pin_low: assert property (selected && $fell(dq_oe_n) |-> !switch_output_pin_in)
    else $error("zero sent with pin high");
  a_one_pin_high: assert property
    (selected && switch_output_pin_in && $fell(dq_in) |-> dq_oe_n [*6])
    else $error("pin high but line pulled");
  a_presence_due: assert property (s_bus_reset |-> ##[PW_LO:PW_HI] !dq_oe_n)
    else $error("no presence after bus reset");
  a_reset_deselect: assert property (s_bus_reset |-> ##[1:4] !selected)
    else $error("still selected after bus reset");
  a_toggle_selects: assert property ($changed(switch_on) |-> ##[0:2] selected)
    else $error("switch toggled without match");
endmodule : asw_slave_checker
bind asw_slave asw_slave_checker #(.RESET_CYC(RESET_CYC), .PRES_WAIT_CYC(PRES_WAIT_CYC),
  .PRES_LEN_CYC(PRES_LEN_CYC)) chk_inst (.clk, .rst_n, .dq_in, .dq_out, .dq_oe_n,
  .switch_output_pin_in, .switch_output_pin_out, .switch_output_pin_oe_n, .switch_on,
  .selected);

//--- dv/asw_master_model.sv
// Bus master model: reset with presence watch, write and read slots.
// Assumes the bench resolves the line from pull and the slave pulldown.
`timescale 1ns/1ns
module asw_master_model (
  // Clock and line
  input wire logic clk,
  input wire logic dq,
  // Master pulldown request
  output logic pull
);
  initial pull = 1'b0;
  // Long low, then watch the released line for presence
  task automatic bus_reset(output logic pres);
    @(negedge clk);
    pull = 1'b1;
    repeat (250) @(negedge clk);
    pull = 1'b0;
    pres = 1'b0;
    repeat (150) begin
      @(negedge clk);
      if (!dq) pres = 1'b1;
    end
  endtask : bus_reset
  // Low of 6 cycles covers the slave's sync delay, so no glitch
  task automatic slot(input logic b, output logic r);
    pull = 1'b1;
    repeat (6) @(negedge clk);
    if (b) pull = 1'b0;
    repeat (8) @(negedge clk);
    r = dq;
    repeat (18) @(negedge clk);
    pull = 1'b0;
    repeat (10) @(negedge clk);
  endtask : slot
  task automatic wr_byte(input logic [7:0] v);
    logic r;
    for (int i = 0; i < 8; i++) slot(v[i], r);
  endtask : wr_byte
  task automatic rd_byte(output logic [7:0] v);
    for (int i = 0; i < 8; i++) slot(1'b1, v[i]);
  endtask : rd_byte
endmodule : asw_master_model

//--- dv/asw_slave_tb.sv
// Bench for the switch slave: master model on the line, pin pulled up.
// Assumes shortened timing; expectations come from the package id.
`timescale 1ns/1ns
module asw_slave_tb;
  localparam logic [63:0] ID = asw_pkg::ID_DEFAULT;
  logic clk, rst_n, pull, dq_oe_n, sw_oe_n, switch_on, selected, pres, r, c;
  logic [7:0] b;
  logic [63:0] q;
  int miscompares = 0;
  int n_tests = 0;
  // Pullups on both lines
  wire logic dq = !pull && dq_oe_n;
  wire logic sw_pin = sw_oe_n;
  asw_slave #(.RESET_CYC(200), .PRES_WAIT_CYC(10), .PRES_LEN_CYC(40), .SAMPLE_CYC(20),
    .RDHOLD_CYC(30)) asw_slave_inst (.clk, .rst_n, .dq_in(dq), .dq_out(), .dq_oe_n,
    .switch_output_pin_in(sw_pin), .switch_output_pin_out(),
    .switch_output_pin_oe_n(sw_oe_n), .switch_on, .selected);
  asw_master_model asw_master_model_inst (.clk, .dq, .pull);
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic close_out();
    $display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out
  task automatic sl(input logic v, output logic o);
    asw_master_model_inst.slot(v, o);
  endtask : sl
  // No presence means a dead bus: no command goes out then
  task automatic open(input logic [7:0] cmd);
    asw_master_model_inst.bus_reset(pres);
    check(pres, 1'b1);
    if (pres) asw_master_model_inst.wr_byte(cmd);
  endtask : open
  task automatic do_match(input logic [63:0] id);
    open(asw_pkg::CMD_MATCH);
    for (int i = 0; i < 8; i++) asw_master_model_inst.wr_byte(id[8*i+:8]);
  endtask : do_match
  task automatic t_match();
    do_match(ID);
    check(switch_on, 1'b1);
    for (int k = 0; k < 2; k++) begin
      asw_master_model_inst.rd_byte(b);
      check(b, 8'h00);
    end
    do_match(ID);
    check(switch_on, 1'b0);
    asw_master_model_inst.rd_byte(b);
    check(b, 8'hff);
  endtask : t_match
  task automatic t_refused(input logic [7:0] cmd);
    if (cmd == asw_pkg::CMD_MATCH)
      do_match(ID ^ {1'b1, 63'h0});
    else
      open(cmd);
    check({switch_on, selected}, 2'b00);
    asw_master_model_inst.rd_byte(b);
    check(b, 8'hff);
  endtask : t_refused
  task automatic t_read_id();
    open(asw_pkg::CMD_READ_ID);
    for (int i = 0; i < 8; i++) asw_master_model_inst.rd_byte(q[8*i+:8]);
    check(q, ID);
  endtask : t_read_id
  task automatic t_search(input logic [7:0] cmd, input logic act, input logic [7:0] lvl);
    open(cmd);
    for (int i = 0; i < 64; i++) begin
      sl(1'b1, r);
      sl(1'b1, c);
      check({r, c}, act ? {ID[i], !ID[i]} : 2'b11);
      sl(ID[i], r);
    end
    asw_master_model_inst.rd_byte(b);
    check(b, lvl);
  endtask : t_search
  task automatic t_search_lose();
    open(asw_pkg::CMD_SEARCH);
    sl(1'b1, r);
    sl(1'b1, c);
    sl(!ID[0], r);
    sl(1'b1, r);
    sl(1'b1, c);
    check({r, c, selected}, 3'b110);
  endtask : t_search_lose
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog: whole run needs about 50000 cycles
  initial begin
    #900000;
    miscompares++;
    close_out();
  end
  initial begin
    rst_n = 1'b0;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    t_match();
    t_refused(asw_pkg::CMD_MATCH);
    t_refused(asw_pkg::CMD_SKIP);
    t_read_id();
    t_search(asw_pkg::CMD_SEARCH, 1'b1, 8'hff);
    t_search(asw_pkg::CMD_SEARCH_ACT, 1'b0, 8'hff);
    do_match(ID);
    check(switch_on, 1'b1);
    t_search(asw_pkg::CMD_SEARCH_ACT, 1'b1, 8'h00);
    t_search_lose();
    close_out();
  end
endmodule : asw_slave_tb
